// file: src/dsr_pkg.sv
// Package for the decoder status register bank: offsets, bit positions,
// reset values, the gain step table and the decoder status carrier.
// Assumes one clock domain shared by the host port and the decoder core.
`default_nettype none
package dsr_pkg;
   // Register offsets on the serial control port
   localparam logic [7:0] OFF_INT_RESET_B = 8'h1c;
   localparam logic [7:0] OFF_FW_MINOR    = 8'h83;
   localparam logic [7:0] OFF_LC_HIGH     = 8'h84;
   localparam logic [7:0] OFF_LC_LOW      = 8'h85;
   localparam logic [7:0] OFF_INT_SRC_B   = 8'h86;
   localparam logic [7:0] OFF_INT_ACT_B   = 8'h87;
   localparam logic [7:0] OFF_STATUS1     = 8'h88;
   localparam logic [7:0] OFF_STATUS2     = 8'h89;
   localparam logic [7:0] OFF_STATUS3     = 8'h8a;

   // Interrupt source register B bit positions
   localparam int BIT_SW_INIT   = 7;
   localparam int BIT_CMD_READY = 5;
   localparam int CHG_W         = 5;

   // Reset values
   localparam logic [7:0]       RST_BYTE  = 8'h00;
   localparam logic [CHG_W-1:0] RST_FLAGS = 5'h00;
   localparam logic [7:0]       FW_MIN    = 8'h01;

   // Gain product: (15 + 3*a) * (4096 + step*d), full scale 15*4096
   localparam int              GAIN_W     = 19;
   localparam logic [5:0]      ANA_BASE   = 6'h0f;
   localparam logic [13:0]     DIG_BASE   = 14'h1000;
   localparam logic [5:0]      GAIN_STEP [16] = '{
      6'd61, 6'd55, 6'd48, 6'd44, 6'd38, 6'd33, 6'd29, 6'd26,
      6'd24, 6'd22, 6'd20, 6'd19, 6'd18, 6'd17, 6'd16, 6'd15};

   // Decoder core status, sampled on the same clock
   typedef struct packed {
      logic       peak_white;
      logic       line_alternating;
      logic       field_rate_50hz;
      logic       color_lock;
      logic       v_lock;
      logic       h_lock;
      logic       broadcast_or_tape_source;
      logic       weak_signal;
      logic       line_alt_switch_odd;
      logic       odd_field;
      logic       gain_frozen;
      logic [3:0] analog_gain;
      logic [5:0] digital_gain;
      logic [9:0] line_count;
   } dsr_video_s;
endpackage
`default_nettype wire

// file: src/dsr_gain_calc.sv
// Front-end gain product from the analog and digital gain settings.
// Assumes settings come from logic on the same clock.
`default_nettype none
module dsr_gain_calc (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        sys_rst,
   // Gain settings
   input  wire logic [3:0]                  analog_gain,
   input  wire logic [5:0]                  digital_gain,
   // Product, full scale 15*4096
   output logic      [dsr_pkg::GAIN_W-1:0]  gain_product
);
   logic [dsr_pkg::GAIN_W-1:0] next_gain_product;

   function automatic logic [5:0] step_of(input logic [3:0] a);
      step_of = dsr_pkg::GAIN_STEP[a];
   endfunction

   always_comb begin
      logic [5:0]  ana_term;
      logic [13:0] dig_term;
      ana_term = 6'h00;
      dig_term = 14'h0000;
      ana_term = dsr_pkg::ANA_BASE + 6'(3 * analog_gain);
      dig_term = dsr_pkg::DIG_BASE + 14'(step_of(analog_gain) * digital_gain); // RULE17
      next_gain_product = dsr_pkg::GAIN_W'(ana_term * dig_term); // RULE16
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gain_product <= '0;
      end else begin
         gain_product <= next_gain_product;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_gain_low;
      analog_gain == 4'h0 |=> gain_product == 19'(15 * (4096 + 61 * $past(digital_gain)));
   endproperty
   a_gain_low: assert property (p_gain_low) else $error("gain at analog 0 wrong"); // RULE16

   property p_gain_high;
      analog_gain == 4'hf |=> gain_product == 19'(60 * (4096 + 15 * $past(digital_gain)));
   endproperty
   a_gain_high: assert property (p_gain_high) else $error("gain at analog 15 wrong"); // RULE17
endmodule
`default_nettype wire

// file: src/dsr_status_bank.sv
// Status and interrupt register bank for one decoder channel, read by the
// host over the serial control port. Decoder status arrives on core_clk.
// Notes on behaviour
// [RULE1] Line count is 10 bits: bits 9..8 at 84h, bits 7..0 at 85h.
// [RULE2] Firmware minor version reads 1 to 255 once firmware is present.
// [RULE3] Source B bit 7 shows software initialisation done, 0 before.
// [RULE4] Source B bit 5 shows readiness for a new command, 0 otherwise.
// [RULE5] Source B bits 4..0 set on field rate, alternation, colour, H/V, source change.
// [RULE6] A set source flag stays until host writes 1 to matching bit at 1Ch.
// [RULE7] Interrupt active register reads 1 while interrupt B terminal is asserted.
// [RULE8] Status 1 bits 3,2,1 give colour, vertical, horizontal lock.
// [RULE9] Status 1 bit 4 sets on lost lock, cleared by reading status 1.
// [RULE10] Status 1 bit 6 line alternation, bit 5 field rate 50 Hz.
// [RULE11] Status 1 bit 7 shows peak white detected.
// [RULE12] Status 1 bit 0 reads 0 for broadcast, 1 for tape source.
// [RULE13] Status 2 bit 6 weak signal, bit 5 alternation switch of odd field.
// [RULE14] Status 2 bit 4 odd field, bit 3 gain and offset frozen.
// [RULE15] Status 3 holds analog gain high nibble, digital gain top bits low.
// [RULE16] Gain product is (1+3a/15)*(1+step*d/4096).
// [RULE17] Gain step comes from a 16-entry table indexed by analog gain.
// [RULE18] Host writes to status registers change nothing reported.
`default_nettype none
module dsr_status_bank (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        sys_rst,
   // Host register port
   input  wire logic [7:0]                  host_addr,
   input  wire logic                        host_rd,
   input  wire logic                        host_wr,
   input  wire logic [7:0]                  host_wdata,
   output logic      [7:0]                  host_rdata,
   output logic                             host_rvalid,
   // Decoder core status
   input  wire dsr_pkg::dsr_video_s         video,
   input  wire logic [7:0]                  fw_minor_version,
   input  wire logic                        fw_present,
   input  wire logic                        sw_init_done,
   input  wire logic                        cmd_ready,
   // Interrupt terminal and gain
   output logic                             int_b,
   output logic      [dsr_pkg::GAIN_W-1:0]  gain_product
);
   logic [dsr_pkg::CHG_W-1:0] watch;
   logic [dsr_pkg::CHG_W-1:0] prev;
   logic [dsr_pkg::CHG_W-1:0] next_prev;
   logic [dsr_pkg::CHG_W-1:0] diff;
   logic [dsr_pkg::CHG_W-1:0] chg_flags;
   logic [dsr_pkg::CHG_W-1:0] next_chg_flags;
   logic [dsr_pkg::CHG_W-1:0] wr_clear;
   logic                      prev_valid;
   logic                      next_prev_valid;
   logic                      lost_lock;
   logic                      next_lost_lock;
   logic                      lock_fall;
   logic                      rd_status1;
   logic                      next_int_b;
   logic [7:0]                next_rdata;
   logic [7:0]                fw_shown;
   logic [1:0]                lc_hi;
   logic [7:0]                lc_lo;

   // Watched conditions in source register bit order 4..0
   assign watch = {video.field_rate_50hz, video.line_alternating, video.color_lock,
                   video.h_lock & video.v_lock, video.broadcast_or_tape_source};
   assign diff       = prev_valid ? (watch ^ prev) : dsr_pkg::RST_FLAGS;
   assign wr_clear   = (host_wr && host_addr == dsr_pkg::OFF_INT_RESET_B)
                       ? host_wdata[dsr_pkg::CHG_W-1:0] : dsr_pkg::RST_FLAGS; // RULE18
   assign rd_status1 = host_rd && host_addr == dsr_pkg::OFF_STATUS1;
   assign lock_fall  = prev_valid && prev[1] && !watch[1];
   assign lc_hi      = video.line_count[9:8];
   assign lc_lo      = video.line_count[7:0];

   // A version of zero would read as "no firmware", so it is lifted to one
   assign fw_shown = !fw_present ? dsr_pkg::RST_BYTE
                   : (fw_minor_version == dsr_pkg::RST_BYTE) ? dsr_pkg::FW_MIN
                   : fw_minor_version; // RULE2

   // Change tracking and sticky flags
   always_comb begin
      next_prev       = watch;
      next_prev_valid = 1'b1;
      // A change in the clearing cycle wins over the clear
      next_chg_flags  = (chg_flags & ~wr_clear) | diff; // RULE5 RULE6
      // Lost lock also wins over the clearing read
      next_lost_lock  = (lost_lock && !rd_status1) || lock_fall; // RULE9
      next_int_b      = |next_chg_flags; // RULE7
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev       <= dsr_pkg::RST_FLAGS;
         prev_valid <= 1'b0;
         chg_flags  <= dsr_pkg::RST_FLAGS;
         lost_lock  <= 1'b0;
         int_b      <= 1'b0;
      end else begin
         prev       <= next_prev;
         prev_valid <= next_prev_valid;
         chg_flags  <= next_chg_flags;
         lost_lock  <= next_lost_lock;
         int_b      <= next_int_b;
      end
   end

   // Read data mux; writes never reach these registers
   always_comb begin
      next_rdata = dsr_pkg::RST_BYTE;
      if (host_rd) begin
         case (host_addr)
            dsr_pkg::OFF_FW_MINOR: begin
               next_rdata = fw_shown; // RULE2
            end
            dsr_pkg::OFF_LC_HIGH: begin
               next_rdata = {6'h00, lc_hi}; // RULE1
            end
            dsr_pkg::OFF_LC_LOW: begin
               next_rdata = lc_lo; // RULE1
            end
            dsr_pkg::OFF_INT_SRC_B: begin
               next_rdata[dsr_pkg::BIT_SW_INIT]   = sw_init_done; // RULE3
               next_rdata[dsr_pkg::BIT_CMD_READY] = cmd_ready; // RULE4
               next_rdata[dsr_pkg::CHG_W-1:0]     = chg_flags; // RULE5
            end
            dsr_pkg::OFF_INT_ACT_B: begin
               next_rdata = {7'h00, int_b}; // RULE7
            end
            dsr_pkg::OFF_STATUS1: begin
               next_rdata = {video.peak_white, // RULE11
                             video.line_alternating, // RULE10
                             video.field_rate_50hz,
                             lost_lock, // RULE9
                             video.color_lock, // RULE8
                             video.v_lock,
                             video.h_lock,
                             video.broadcast_or_tape_source}; // RULE12
            end
            dsr_pkg::OFF_STATUS2: begin
               next_rdata = {1'b0, video.weak_signal, // RULE13
                             video.line_alt_switch_odd,
                             video.odd_field, // RULE14
                             video.gain_frozen, 3'h0};
            end
            dsr_pkg::OFF_STATUS3: begin
               next_rdata = {video.analog_gain, video.digital_gain[5:2]}; // RULE15
            end
            default: begin
               next_rdata = dsr_pkg::RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_rdata  <= dsr_pkg::RST_BYTE;
         host_rvalid <= 1'b0;
      end else begin
         host_rdata  <= next_rdata;
         host_rvalid <= host_rd;
      end
   end

   dsr_gain_calc u_gain (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .analog_gain  (video.analog_gain),
      .digital_gain (video.digital_gain),
      .gain_product (gain_product)
   );

   // Helper views for the checks below
   logic [dsr_pkg::CHG_W-1:0] keep;
   logic [3:0]                lock_view;
   logic [3:0]                st2_view;
   logic [7:0]                st3_view;
   logic [dsr_pkg::CHG_W-1:0] cleared;
   logic [1:0]                rate_view;
   logic                      peak_view;
   assign keep      = chg_flags & ~wr_clear;
   assign lock_view = {lost_lock, video.color_lock, video.v_lock, video.h_lock};
   assign st2_view  = {video.weak_signal, video.line_alt_switch_odd,
                       video.odd_field, video.gain_frozen};
   assign st3_view  = {video.analog_gain, video.digital_gain[5:2]};
   assign cleared   = wr_clear & ~diff;
   assign rate_view = {video.line_alternating, video.field_rate_50hz};
   assign peak_view = video.peak_white;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_line_count;
      host_rd && host_addr == dsr_pkg::OFF_LC_HIGH
         |=> host_rvalid && host_rdata == {6'h00, $past(lc_hi)};
   endproperty
   a_line_count: assert property (p_line_count) else $error("line count high wrong"); // RULE1

   property p_fw_minor;
      host_rd && host_addr == dsr_pkg::OFF_FW_MINOR && fw_present |=> host_rdata != 8'h00;
   endproperty
   a_fw_minor: assert property (p_fw_minor) else $error("firmware version zero"); // RULE2

   property p_sw_init;
      host_rd && host_addr == dsr_pkg::OFF_INT_SRC_B
         |=> host_rdata[7] == $past(sw_init_done) && host_rdata[6] == 1'b0;
   endproperty
   a_sw_init: assert property (p_sw_init) else $error("init bit wrong"); // RULE3

   property p_cmd_ready;
      host_rd && host_addr == dsr_pkg::OFF_INT_SRC_B |=> host_rdata[5] == $past(cmd_ready);
   endproperty
   a_cmd_ready: assert property (p_cmd_ready) else $error("command ready bit wrong"); // RULE4

   property p_change_sets;
      diff != 5'h00 |=> (chg_flags & $past(diff)) == $past(diff) && int_b;
   endproperty
   a_change_sets: assert property (p_change_sets) else $error("change flag not set"); // RULE5

   property p_flag_holds;
      keep != 5'h00 |=> (chg_flags & $past(keep)) == $past(keep);
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("flag lost early"); // RULE6

   property p_flag_clears;
      cleared != 5'h00 |=> (chg_flags & $past(cleared)) == 5'h00;
   endproperty
   a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared"); // RULE6

   property p_int_active;
      host_rd && host_addr == dsr_pkg::OFF_INT_ACT_B
         |=> host_rdata == {7'h00, $past(int_b)} && int_b == (chg_flags != 5'h00);
   endproperty
   a_int_active: assert property (p_int_active) else $error("interrupt active wrong"); // RULE7

   property p_status1_lock;
      host_rd && host_addr == dsr_pkg::OFF_STATUS1
         |=> host_rdata[4:1] == $past(lock_view) && host_rdata[0] == $past(watch[0]);
   endproperty
   a_status1_lock: assert property (p_status1_lock) else $error("status 1 wrong"); // RULE8

   property p_lost_lock;
      lock_fall |=> lost_lock ##1 (lost_lock || $past(rd_status1));
   endproperty
   a_lost_lock: assert property (p_lost_lock) else $error("lost lock not kept"); // RULE9

   property p_lost_clear;
      rd_status1 && !lock_fall |=> !lost_lock;
   endproperty
   a_lost_clear: assert property (p_lost_clear) else $error("lost lock not cleared"); // RULE9

   property p_status2;
      host_rd && host_addr == dsr_pkg::OFF_STATUS2 |=> host_rdata[6:3] == $past(st2_view);
   endproperty
   a_status2: assert property (p_status2) else $error("status 2 wrong"); // RULE13

   property p_status3;
      host_rd && host_addr == dsr_pkg::OFF_STATUS3 |=> host_rdata == $past(st3_view);
   endproperty
   a_status3: assert property (p_status3) else $error("status 3 wrong"); // RULE15

   property p_write_ignored;
      host_wr && !host_rd && host_addr == dsr_pkg::OFF_STATUS1 && lost_lock |=> lost_lock;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write changed status"); // RULE18

   // Read port timing, reserved bits and writes that must leave flags alone
   property p_read_answer;
      host_rd |=> host_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered"); // RULE1

   property p_idle_answer;
      !host_rd |=> !host_rvalid && host_rdata == 8'h00;
   endproperty
   a_idle_answer: assert property (p_idle_answer) else $error("data outside a read"); // RULE18

   property p_line_count_low;
      host_rd && host_addr == dsr_pkg::OFF_LC_LOW
         |=> host_rvalid && host_rdata == $past(lc_lo);
   endproperty
   a_line_count_low: assert property (p_line_count_low) else $error("line count low wrong"); // RULE1

   property p_fw_value;
      host_rd && host_addr == dsr_pkg::OFF_FW_MINOR && fw_present
         && fw_minor_version != 8'h00 |=> host_rdata == $past(fw_minor_version);
   endproperty
   a_fw_value: assert property (p_fw_value) else $error("firmware version wrong"); // RULE2

   property p_no_spurious_set;
      diff == 5'h00 |=> (chg_flags & ~$past(chg_flags)) == 5'h00;
   endproperty
   a_no_spurious_set: assert property (p_no_spurious_set) else $error("flag set unasked"); // RULE5

   property p_int_falls;
      keep == 5'h00 && diff == 5'h00 |=> !int_b;
   endproperty
   a_int_falls: assert property (p_int_falls) else $error("interrupt left active"); // RULE7

   property p_other_write;
      host_wr && host_addr != dsr_pkg::OFF_INT_RESET_B
         |=> (chg_flags & $past(chg_flags)) == $past(chg_flags);
   endproperty
   a_other_write: assert property (p_other_write) else $error("write cleared a flag"); // RULE18

   property p_status1_rate;
      host_rd && host_addr == dsr_pkg::OFF_STATUS1
         |=> host_rdata[6:5] == $past(rate_view);
   endproperty
   a_status1_rate: assert property (p_status1_rate) else $error("rate bits wrong"); // RULE10

   property p_peak_white;
      host_rd && host_addr == dsr_pkg::OFF_STATUS1 |=> host_rdata[7] == $past(peak_view);
   endproperty
   a_peak_white: assert property (p_peak_white) else $error("peak white wrong"); // RULE11

   property p_status2_reserved;
      host_rd && host_addr == dsr_pkg::OFF_STATUS2
         |=> host_rdata[7] == 1'b0 && host_rdata[2:0] == 3'h0;
   endproperty
   a_status2_reserved: assert property (p_status2_reserved) else $error("reserved bits set"); // RULE14
endmodule
`default_nettype wire

// file: verification/dsr_host_model.sv
// Host processor model that polls the status bank over its register port.
// Assumes core_clk is the bank's clock; requests change 1 ns after an edge.
`default_nettype none
module dsr_host_model (
   // Clock
   input  wire logic        core_clk,
   // Register port
   output logic      [7:0]  host_addr,
   output logic             host_rd,
   output logic             host_wr,
   output logic      [7:0]  host_wdata,
   input  wire logic [7:0]  host_rdata,
   input  wire logic        host_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      host_addr  = 8'h00;
      host_rd    = 1'b0;
      host_wr    = 1'b0;
      host_wdata = 8'h00;
   end

   // Idle lines show the inverse of their last value so stale data never matches
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      #1;
      host_addr = a;
      host_rd   = 1'b1;
      @(posedge core_clk);
      #1;
      host_rd   = 1'b0;
      host_addr = ~a;
      d = (host_rvalid === 1'b1) ? host_rdata : 8'hxx;
   endtask

   // A 1 in a bit at the reset offset clears the matching source flag
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      host_addr  = a;
      host_wdata = d;
      host_wr    = 1'b1;
      @(posedge core_clk);
      #1;
      host_wr    = 1'b0;
      host_addr  = ~a;
      host_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// file: verification/test_decoder_status_register_bank.sv
// Self-checking bench for the decoder status register bank.
// Assumes one 250 MHz clock; decoder status is driven as plain levels.
`default_nettype none
module test_decoder_status_register_bank;
   timeunit 1ns;
   timeprecision 1ps;

   logic                       core_clk;
   logic                       sys_rst;
   logic [7:0]                 host_addr;
   logic                       host_rd;
   logic                       host_wr;
   logic [7:0]                 host_wdata;
   logic [7:0]                 host_rdata;
   logic                       host_rvalid;
   dsr_pkg::dsr_video_s        v;
   logic [7:0]                 fw_minor_version;
   logic                       fw_present;
   logic                       sw_init_done;
   logic                       cmd_ready;
   logic                       int_b;
   logic [dsr_pkg::GAIN_W-1:0] gain_product;
   int                         n_errors;
   int                         n_tests;
   int                         e;
   logic [7:0]                 m;
   logic [5:0]                 d;
   localparam logic [7:0] STEP [16] = '{8'h3d, 8'h37, 8'h30, 8'h2c, 8'h26, 8'h21, 8'h1d,
      8'h1a, 8'h18, 8'h16, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h0f};

   dsr_status_bank dut (.core_clk(core_clk), .sys_rst(sys_rst), .host_addr(host_addr),
      .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .host_rvalid(host_rvalid), .video(v),
      .fw_minor_version(fw_minor_version), .fw_present(fw_present),
      .sw_init_done(sw_init_done), .cmd_ready(cmd_ready), .int_b(int_b),
      .gain_product(gain_product));

   dsr_host_model host (.core_clk(core_clk), .host_addr(host_addr), .host_rd(host_rd),
      .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid));

   always #2 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      host.rd(a, r);
      check(32'(r), 32'(exp));
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Whole run is under three hundred cycles; this leaves wide margin
   initial begin
      #100000;
      n_errors++;
      results();
   end

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      v = '0;
      fw_minor_version = 8'h00;
      fw_present = 1'b0;
      sw_init_done = 1'b0;
      cmd_ready = 1'b0;
      n_errors = 0;
      n_tests = 0;
      tick(20);
      sys_rst = 1'b0;
      tick(2);
      for (int a = 8'h83; a <= 8'h8a; a++) begin
         rdchk(8'(a), 8'h00);
      end
      check(32'(int_b), 32'h0);
      // Firmware version: a zero while present must still read in range
      fw_present = 1'b1;
      rdchk(8'h83, 8'h01);
      fw_minor_version = 8'hff;
      rdchk(8'h83, 8'hff);
      fw_minor_version = 8'h5a;
      host.wr(8'h83, 8'h00);
      rdchk(8'h83, 8'h5a);
      v.line_count = 10'h30d;
      tick(2);
      rdchk(8'h84, 8'h03);
      rdchk(8'h85, 8'h0d);
      sw_init_done = 1'b1;
      rdchk(8'h86, 8'h80);
      cmd_ready = 1'b1;
      rdchk(8'h86, 8'ha0);
      for (int i = 0; i < 5; i++) begin
         m = 8'(8'h01 << i);
         case (i)
            0: v.broadcast_or_tape_source = 1'b1;
            1: begin
               v.h_lock = 1'b1;
               v.v_lock = 1'b1;
            end
            2: v.color_lock = 1'b1;
            3: v.line_alternating = 1'b1;
            default: v.field_rate_50hz = 1'b1;
         endcase
         tick(3);
         rdchk(8'h86, 8'ha0 | m);
         check(32'(int_b), 32'h1);
         host.wr(8'h86, 8'hff);
         host.wr(8'h1c, ~m);
         rdchk(8'h86, 8'ha0 | m);
         rdchk(8'h87, 8'h01);
         host.wr(8'h1c, m);
         tick(1);
         rdchk(8'h86, 8'ha0);
         rdchk(8'h87, 8'h00);
         check(32'(int_b), 32'h0);
      end
      rdchk(8'h88, 8'h6f);
      v.peak_white = 1'b1;
      host.wr(8'h88, 8'h00);
      rdchk(8'h88, 8'hef);
      // Losing vertical lock alone must flag lost lock until the next read
      v.v_lock = 1'b0;
      tick(3);
      host.wr(8'h88, 8'hff);
      rdchk(8'h88, 8'hfb);
      rdchk(8'h88, 8'heb);
      rdchk(8'h86, 8'ha2);
      host.wr(8'h1c, 8'h1f);
      tick(1);
      rdchk(8'h86, 8'ha0);
      v.weak_signal = 1'b1;
      v.odd_field = 1'b1;
      v.gain_frozen = 1'b1;
      tick(2);
      rdchk(8'h89, 8'h58);
      v.weak_signal = 1'b0;
      v.line_alt_switch_odd = 1'b1;
      v.odd_field = 1'b0;
      v.gain_frozen = 1'b0;
      tick(2);
      rdchk(8'h89, 8'h20);
      for (int a = 0; a < 16; a++) begin
         d = 6'((a * 7 + 5) % 64);
         if (a == 15) d = 6'h3f;
         v.analog_gain = 4'(a);
         v.digital_gain = d;
         tick(3);
         e = (15 + 3 * a) * (4096 + int'(STEP[a]) * int'(d));
         check(32'(gain_product), 32'(e));
         rdchk(8'h8a, {4'(a), d[5:2]});
      end
      host.wr(8'h8a, 8'h00);
      rdchk(8'h8a, 8'hff);
      rdchk(8'h8b, 8'h00);
      results();
   end
endmodule
`default_nettype wire
